// [diag_run_state_supervisor_tb_top.sv]
`timescale 1ns/1ps
module diag_run_state_supervisor_tb_top;
  logic clk = 1'b0, reset = 1'b1, diag_init_done = 1'b0, modbus_init_done = 1'b0;
  logic modbus_frame_valid = 1'b0, modbus_fault = 1'b0, fault_cleared = 1'b0, start_cmd = 1'b0;
  logic send = 1'b0, corrupt = 1'b0, diag_frame_valid, diag_frame_bad, image_update;
  logic chain_contact_closed;
  logic [4:0] switch_count = 5'h05;
  logic [79:0] words = '0, diag_frame_data, reg_image;
  logic [1:0] diag_led, modbus_led, run_state, exp_s;
  int bad_count = 0, n_tests = 0, cycles = 0, seed = 32'h7a030563;
  drs_supervisor drs_supervisor_inst (.*);
  drs_chain_model drs_chain_model_inst (.clk(clk), .send(send), .corrupt(corrupt),
    .words(words), .valid(diag_frame_valid), .bad(diag_frame_bad), .data(diag_frame_data));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cycles == 500) complete_run(1);
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) bad_count++;
    if (seen !== exp) $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  function automatic logic [1:0] state_after(input logic [1:0] s, input logic [1:0] cmd);
    return (s == 2'h2 && cmd == 2'h3) ? 2'h1 : s;
  endfunction : state_after
  task automatic complete_run(input int extra);
    bad_count += extra;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    step(2);
    reset = 1'b0;
    step(3);
    check({run_state, diag_led, modbus_led, chain_contact_closed}, 7'h14);
    diag_init_done = 1'b1;
    words = '1;
    send = 1'b1;
    step(1);
    send = 1'b0;
    step(1);
    check(run_state, 2'h0);
    check(reg_image, 80'h0);
    check(image_update, 1'b0);
    modbus_init_done = 1'b1;
    step(2);
    check({run_state, chain_contact_closed}, 3'h3);
    send = 1'b1;
    repeat (6) begin
      words = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      step(1);
      check(reg_image, words);
      check({image_update, diag_led}, 3'h4);
    end
    send = 1'b0;
    modbus_frame_valid = 1'b1;
    step(1);
    modbus_frame_valid = 1'b0;
    check(modbus_led, 2'h0);
    modbus_fault = 1'b1;
    step(3);
    check({modbus_led, chain_contact_closed, run_state}, 5'h1d);
    modbus_fault = 1'b0;
    step(3);
    check(modbus_led == 2'h3, 1'b0);
    corrupt = 1'b1;
    send = 1'b1;
    step(1);
    send = 1'b0;
    corrupt = 1'b0;
    check({run_state, chain_contact_closed}, 3'h4);
    exp_s = 2'h2;
    for (int i = 0; i < 4; i++) begin
      {start_cmd, fault_cleared} = i[1:0];
      step(1);
      exp_s = state_after(exp_s, i[1:0]);
      check(run_state, exp_s);
    end
    switch_count = 5'h06;
    step(3);
    check({run_state, chain_contact_closed, diag_led}, 5'h1b);
    complete_run(0);
  end
endmodule : diag_run_state_supervisor_tb_top

// [drs_chain_model.sv]
`timescale 1ns/1ps
// ********
// Switch chain frame source
// ********
module drs_chain_model (
  // Clock
  input wire logic clk,
  // Frame request
  input wire logic send,
  input wire logic corrupt,
  input wire logic [79:0] words,
  // Frame out
  output logic valid,
  output logic bad,
  output logic [79:0] data
);
  logic [79:0] last = '0;
  // Between frames the lines carry junk, so a stale frame can never look valid.
  assign valid = send;
  assign bad = send & corrupt;
  assign data = send ? words : ~last;
  always_ff @(posedge clk) if (send) last <= words;
endmodule : drs_chain_model

// [drs_flash_if.sv]
`timescale 1ns/1ps
interface drs_flash_if;
  logic trigger;
  logic active;
  modport owner (output trigger, input active);
  modport flasher (input trigger, output active);
endinterface : drs_flash_if

// [drs_flasher.sv]
`timescale 1ns/1ps
module drs_flasher (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Trigger and flash output
  drs_flash_if.flasher fl
);

  logic [drs_pkg::FLASH_W-1:0] count;

  // A new trigger restarts the flash so that bursts stay visible.
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (fl.trigger) begin
      count <= drs_pkg::FLASH_W'(drs_pkg::FLASH_CYC);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign fl.active = (count != '0);

endmodule : drs_flasher

// [drs_pkg.sv]
package drs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FRAME_TIMEOUT_S = 3;
  localparam longint unsigned TIMEOUT_CYC_L = longint'(FRAME_TIMEOUT_S) * longint'(CLK_HZ);
  localparam int unsigned TIMEOUT_CYC = int'(TIMEOUT_CYC_L);
  localparam int unsigned FLASH_MS = 50;
  localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W = 32;
  localparam int unsigned FLASH_W = 24;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned COUNT_W = 5;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned IMAGE_WORDS = 5;
  localparam logic [15:0] IMAGE_RESET = 16'h0000;

  // ****************************************************************
  // LED colour codes
  // ****************************************************************
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_ORANGE = 2'h2;
  localparam logic [1:0] LED_RED = 2'h3;

  typedef enum logic [1:0] {
    DRS_INIT = 2'b00,
    DRS_RUN = 2'b01,
    DRS_ERROR = 2'b10,
    DRS_LOCKED = 2'b11
  } drs_state_t;

endpackage : drs_pkg

// [drs_props.sv]
`timescale 1ns/1ps
// ********
// Run-state checker
// ********
module drs_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs
  input wire logic diag_init_done,
  input wire logic modbus_init_done,
  input wire logic diag_frame_valid,
  input wire logic diag_frame_bad,
  input wire logic modbus_fault,
  input wire logic fault_cleared,
  input wire logic start_cmd,
  // Outputs
  input wire logic image_update,
  input wire logic [1:0] diag_led,
  input wire logic [1:0] modbus_led,
  input wire logic chain_contact_closed,
  input wire logic [1:0] run_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // The timeout is too long to reach in a short run; this counter still guards the limit.
  logic [31:0] quiet;
  always_ff @(posedge clk) begin
    if (reset || run_state != 2'h1 || (diag_frame_valid && !diag_frame_bad)) begin
      quiet <= 32'h0;
    end else begin
      quiet <= quiet + 32'h1;
    end
  end
  a_frame_timeout:
    assert property (run_state == 2'h1 && quiet == 32'(drs_pkg::TIMEOUT_CYC - 1) |=>
      run_state != 2'h1) else $error("frame timeout missed");
  sequence good_frame; run_state == 2'h1 && diag_frame_valid && !diag_frame_bad; endsequence
  a_init_wait:
    assert property (run_state == 2'h0 && !(diag_init_done && modbus_init_done) |=>
      run_state != 2'h1) else $error("early run");
  a_image_load:
    assert property (good_frame |=> image_update) else $error("no update");
  a_bad_frame:
    assert property (run_state == 2'h1 && diag_frame_valid && diag_frame_bad |=>
      run_state == 2'h2 && !chain_contact_closed) else $error("bad frame");
  a_error_hold:
    assert property (run_state == 2'h2 && !(fault_cleared && start_cmd) |=> run_state[1])
      else $error("left error");
  a_diag_flash:
    assert property (good_frame |=> diag_led == 2'h0) else $error("no flash");
  a_modbus_contact:
    assert property ($changed(modbus_fault) && run_state == 2'h1 && !diag_frame_valid |=>
      chain_contact_closed) else $error("contact moved");
  a_init_outputs:
    assert property (run_state == 2'h0 |-> diag_led == 2'h2 && modbus_led == 2'h2 &&
      !chain_contact_closed) else $error("init outputs");
  a_locked_stays:
    assert property (run_state == 2'h3 |=> run_state == 2'h3) else $error("unlocked");
endmodule : drs_props
bind drs_supervisor drs_props drs_props_inst (.*);

// [drs_supervisor.sv]
`timescale 1ns/1ps
// What this block does
// - Enter run only after diagnostic and Modbus initialization both finish.
// - Every good diagnostic frame received after initialization refreshes the Modbus-readable register image.
// - In run, three seconds without a diagnostic frame means error.
// - An incorrect diagnostic frame sends the device to error.
// - Error holds until fault removed and a new start is given.
// - In run, flash the diagnostic LED on each diagnostic frame received; in error and locked it stays red.
// - Flash the Modbus LED on each Modbus frame received.
// - Modbus faults clear themselves when the fault goes away, no restart.
// - Modbus faults never affect the chain-fault contact.
// - During initialization both LEDs orange and chain-fault contact open.
// - Switch count latched at start; a change locks error until power cycle.
module drs_supervisor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Initialization status
  input wire logic diag_init_done,
  input wire logic modbus_init_done,
  // Switch count setting
  input wire logic [drs_pkg::COUNT_W-1:0] switch_count,
  // Diagnostic frame receiver
  input wire logic diag_frame_valid,
  input wire logic diag_frame_bad,
  input wire logic [drs_pkg::WORD_W*drs_pkg::IMAGE_WORDS-1:0] diag_frame_data,
  // Modbus receiver
  input wire logic modbus_frame_valid,
  input wire logic modbus_fault,
  // Operator
  input wire logic fault_cleared,
  input wire logic start_cmd,
  // Register image
  output logic [drs_pkg::WORD_W*drs_pkg::IMAGE_WORDS-1:0] reg_image,
  output logic image_update,
  // Indicators and contact
  output logic [1:0] diag_led,
  output logic [1:0] modbus_led,
  output logic chain_contact_closed,
  output logic [1:0] run_state
);

  // ****************************************************************
  // State
  // ****************************************************************
  drs_pkg::drs_state_t state;
  drs_pkg::drs_state_t next_state;
  logic [drs_pkg::TMR_W-1:0] timer;
  logic [drs_pkg::COUNT_W-1:0] latched_count;
  logic count_taken;

  // ****************************************************************
  // Flash units
  // ****************************************************************
  // One flasher per LED keeps the two indications independent of each other.
  drs_flash_if diag_fl ();
  drs_flash_if mb_fl ();

  drs_flasher u_diag_flash (
    .clk(clk),
    .reset(reset),
    .fl(diag_fl.flasher)
  );

  drs_flasher u_mb_flash (
    .clk(clk),
    .reset(reset),
    .fl(mb_fl.flasher)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Frames only count once the block has left initialization.
  function automatic logic frames_open(input drs_pkg::drs_state_t s);
    return s != drs_pkg::DRS_INIT;
  endfunction : frames_open

  // A flashing LED goes dark for the flash time and then shows green again.
  function automatic logic [1:0] flash_colour(input logic flashing);
    return flashing ? drs_pkg::LED_OFF : drs_pkg::LED_GREEN;
  endfunction : flash_colour

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire good_frame = diag_frame_valid && !diag_frame_bad;
  wire bad_frame = diag_frame_valid && diag_frame_bad;
  wire in_run = (state == drs_pkg::DRS_RUN);
  // At 200 MHz the three second limit lies far beyond any practical simulation run.
  wire timed_out = in_run && (timer >= drs_pkg::TMR_W'(drs_pkg::TIMEOUT_CYC - 1));
  wire count_changed = count_taken && (switch_count != latched_count);
  wire init_done = diag_init_done && modbus_init_done;
  // Clearing the cause alone is not enough: both must stand at one edge.
  wire restart_ok = fault_cleared && start_cmd;
  wire accept_frame = good_frame && frames_open(state);

  assign diag_fl.trigger = diag_frame_valid && frames_open(state);
  assign mb_fl.trigger = modbus_frame_valid && frames_open(state);
  // The trigger is counted as well, so the flash shows with the image update.
  wire diag_flash_on = diag_fl.trigger || diag_fl.active;
  wire mb_flash_on = mb_fl.trigger || mb_fl.active;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Modbus fault is deliberately absent here: the contact only follows the chain.
  always_comb begin
    next_state = state;
    case (state)
      drs_pkg::DRS_INIT: begin
        if (init_done) begin
          next_state = drs_pkg::DRS_RUN;
        end
      end
      drs_pkg::DRS_RUN: begin
        if (bad_frame || timed_out) begin
          next_state = drs_pkg::DRS_ERROR;
        end
      end
      drs_pkg::DRS_ERROR: begin
        if (restart_ok) begin
          next_state = drs_pkg::DRS_RUN;
        end
      end
      drs_pkg::DRS_LOCKED: begin
        next_state = drs_pkg::DRS_LOCKED;
      end
      default: begin
        next_state = drs_pkg::DRS_INIT;
      end
    endcase
    if (count_changed) begin
      next_state = drs_pkg::DRS_LOCKED;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= drs_pkg::DRS_INIT;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Switch count and frame timeout
  // ****************************************************************
  // A locked block leaves only through reset, which stands in for a power cycle.
  // The count is caught by a clocked process after reset, never by the reset itself.
  always_ff @(posedge clk) begin
    if (reset) begin
      count_taken <= 1'b0;
      latched_count <= '0;
    end else if (!count_taken) begin
      count_taken <= 1'b1;
      latched_count <= switch_count;
    end
  end

  // Timer restarts on any good frame and on entering run.
  // It stops at the limit, so a long quiet spell can never wrap back into run.
  always_ff @(posedge clk) begin
    if (reset) begin
      timer <= '0;
    end else if (!in_run || good_frame) begin
      timer <= '0;
    end else if (!timed_out) begin
      timer <= timer + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_image <= {drs_pkg::IMAGE_WORDS{drs_pkg::IMAGE_RESET}};
      image_update <= 1'b0;
    end else begin
      // Frames taken in error still refresh the image, so software sees the fault.
      image_update <= accept_frame;
      if (accept_frame) begin
        reg_image <= diag_frame_data;
      end
    end
  end

  // ****************************************************************
  // Indicators and contact
  // ****************************************************************
  wire [1:0] next_diag_led = (state == drs_pkg::DRS_INIT) ? drs_pkg::LED_ORANGE :
    (state != drs_pkg::DRS_RUN) ? drs_pkg::LED_RED :
    flash_colour(diag_flash_on);
  // Modbus faults only colour the Modbus LED and recover with the line.
  wire [1:0] next_modbus_led = (state == drs_pkg::DRS_INIT) ? drs_pkg::LED_ORANGE :
    modbus_fault ? drs_pkg::LED_RED :
    flash_colour(mb_flash_on);
  // The contact follows next_state, so it opens in the cycle that run_state leaves run.
  wire next_contact = (next_state == drs_pkg::DRS_RUN);

  always_ff @(posedge clk) begin
    if (reset) begin
      diag_led <= drs_pkg::LED_ORANGE;
      modbus_led <= drs_pkg::LED_ORANGE;
    end else begin
      diag_led <= next_diag_led;
      modbus_led <= next_modbus_led;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chain_contact_closed <= 1'b0;
      run_state <= drs_pkg::DRS_INIT;
    end else begin
      chain_contact_closed <= next_contact;
      run_state <= next_state;
    end
  end

endmodule : drs_supervisor
